//--- cwf_regs.svh
/*
 * Register addresses, field positions, reset values and masks of the
 * selective-wake identifier filter registers.
 * Assumes: included by bare name; addresses are seven-bit serial-interface addresses.
 */
`ifndef CWF_REGS_SVH
`define CWF_REGS_SVH

// register addresses on the serial interface
`define CWF_ADDR_IDENT_HIGH       7'h32
`define CWF_ADDR_IDENT_LOW        7'h33
`define CWF_ADDR_MASK_HIGH        7'h34

// reset values, same for power-on and soft reset
`define CWF_RST_IDENT_LOW         16'h0000
`define CWF_RST_IDENT_HIGH        16'h0000
`define CWF_RST_MASK_HIGH         16'h0000

// writable bits of the identifier-low register (bit 7 reserved)
`define CWF_WMASK_IDENT_LOW       16'hFF7F

// identifier-low field positions
`define CWF_LOW_ID_HI_MSB         15
`define CWF_LOW_ID_HI_LSB         8
`define CWF_LOW_RSVD_BIT          7
`define CWF_LOW_ID_LO_MSB         6
`define CWF_LOW_ID_LO_LSB         2
`define CWF_LOW_RTR_BIT           1
`define CWF_LOW_IDE_BIT           0

`endif

//--- cwf_pkg.sv
/*
 * Types of the selective-wake identifier filter.
 * Assumes: constants come from cwf_regs.svh.
 */
package cwf_pkg;

   // one received frame header handed in by the frame decoder
   typedef struct packed {
      logic [28:0] ident;
      logic        rtr;
      logic        ide;
   } cwf_frame_t;

   // one decoded register access from the serial interface
   typedef struct packed {
      logic [6:0]  addr;
      logic        wrEn;
      logic        rdEn;
      logic [15:0] wrData;
   } cwf_access_t;

endpackage : cwf_pkg

//--- cwf_filter_regs.sv
/*
 * Selective-wake identifier registers and the identifier filter compare.
 * Assumes: serial frame decoding is done upstream and hands in one decoded
 * access per cycle on ref_clk; the frame decoder hands in received headers
 * on the same clock; the low-half mask register lives elsewhere.
 */
`timescale 1ns/100ps
`include "cwf_regs.svh"

// Operation
// R1 - low register bits 15:8 hold ident 12:5
// R2 - low register bits 6:2 hold ident 4:0
// R3 - bit 7 reserved, reads zero, not stored
// R4 - bit 1 selects expected remote request
// R5 - bit 0 selects standard or extended identifier
// R6 - mask-high bits 15:0 mask ident 28:13
// R7 - mask one compares bit, zero ignores
// R8 - power-on or soft reset clears registers
// R9 - restart keeps low register, bit 7 zero
// R10 - restart keeps mask-high register unchanged
// R11 - low register sits at address 0x33
// R12 - separate high register holds ident 28:13
// R13 - config change clears configuration-valid flag
// R14 - match needs masked ident, RTR, IDE equal
// R15 - host programs everything before setting valid
module cwf_filter_regs #(
   parameter int REG_W = 16
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                softRstReq,
   input  wire logic                restartReq,
   input  wire cwf_pkg::cwf_access_t regAccess,
   input  wire logic                configValidSet,
   input  wire logic [12:0]         maskLow,
   input  wire logic                frameValid,
   input  wire cwf_pkg::cwf_frame_t frameIn,
   output logic [REG_W-1:0]         rdData,
   output logic                     rdValid,
   output logic [REG_W-1:0]         identLow,
   output logic [REG_W-1:0]         identHigh,
   output logic [REG_W-1:0]         maskHigh,
   output logic                     configValid,
   output logic                     matchDone,
   output logic                     matchHit
);

   // layout is fixed by the register map
   if (REG_W != 16) begin : g_bad_width
      $error("cwf_filter_regs: REG_W must be 16");
   end

   logic [REG_W-1:0] identLow_q;
   logic [REG_W-1:0] identHigh_q;
   logic [REG_W-1:0] maskHigh_q;
   logic [REG_W-1:0] rdData_q;
   logic             rdValid_q;
   logic             configValid_q;
   logic             matchDone_q;
   logic             matchHit_q;
   logic             clearAll;
   logic             wrLow;
   logic             wrHigh;
   logic             wrMask;
   logic [28:0]      cfgIdent;
   logic [28:0]      cmpMask;
   logic [28:0]      bitOk;

   // power-on and soft reset share one clear path
   assign clearAll = !rst_n || softRstReq; // see R8

   // address decode of write strobes
   assign wrLow  = regAccess.wrEn && (regAccess.addr == `CWF_ADDR_IDENT_LOW);  // see R11
   assign wrHigh = regAccess.wrEn && (regAccess.addr == `CWF_ADDR_IDENT_HIGH);
   assign wrMask = regAccess.wrEn && (regAccess.addr == `CWF_ADDR_MASK_HIGH);

   // identifier-low: reserved bit never stored, so it reads zero after any write
   always_ff @(posedge ref_clk) begin
      if (clearAll) begin
         identLow_q <= `CWF_RST_IDENT_LOW; // see R8
      end else if (restartReq) begin
         identLow_q <= identLow_q & `CWF_WMASK_IDENT_LOW; // see R9
      end else if (wrLow) begin
         identLow_q <= regAccess.wrData & `CWF_WMASK_IDENT_LOW; // see R1 see R2 see R3 see R4 see R5
      end
   end

   // identifier-high keeps its value across a restart
   always_ff @(posedge ref_clk) begin
      if (clearAll) begin
         identHigh_q <= `CWF_RST_IDENT_HIGH;
      end else if (wrHigh) begin
         identHigh_q <= regAccess.wrData; // see R12
      end
   end

   // mask-high keeps its value across a restart
   always_ff @(posedge ref_clk) begin
      if (clearAll) begin
         maskHigh_q <= `CWF_RST_MASK_HIGH; // see R8
      end else if (wrMask) begin
         maskHigh_q <= regAccess.wrData; // see R6 see R10
      end
   end

   // any write to a filter register invalidates the configuration, a maskLow change does not; the clear wins
   // over a set in the same cycle so a half-written filter is never armed
   always_ff @(posedge ref_clk) begin
      if (clearAll || restartReq) begin
         configValid_q <= 1'b0;
      end else if (wrLow || wrHigh || wrMask) begin
         configValid_q <= 1'b0; // see R13
      end else if (configValidSet) begin
         configValid_q <= 1'b1; // see R15
      end
   end

   // read path: one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge ref_clk) begin
      if (clearAll) begin
         rdData_q  <= 16'h0000;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= regAccess.rdEn;
         if (!regAccess.rdEn) begin
            rdData_q <= rdData_q;
         end else if (regAccess.addr == `CWF_ADDR_IDENT_LOW) begin
            rdData_q <= identLow_q; // see R3
         end else if (regAccess.addr == `CWF_ADDR_IDENT_HIGH) begin
            rdData_q <= identHigh_q;
         end else if (regAccess.addr == `CWF_ADDR_MASK_HIGH) begin
            rdData_q <= maskHigh_q;
         end else begin
            rdData_q <= 16'h0000;
         end
      end
   end

   // expected identifier and compare mask gathered into 29-bit form
   assign cfgIdent = {identHigh_q,
                      identLow_q[`CWF_LOW_ID_HI_MSB:`CWF_LOW_ID_HI_LSB],
                      identLow_q[`CWF_LOW_ID_LO_MSB:`CWF_LOW_ID_LO_LSB]};
   assign cmpMask  = {maskHigh_q, maskLow};

   // per-bit compare; a cleared mask bit ignores that identifier bit
   for (genvar i = 0; i < 29; i++) begin : g_cmp
      assign bitOk[i] = !cmpMask[i] || (frameIn.ident[i] == cfgIdent[i]); // see R7
   end

   // compare result registered once per presented frame header
   always_ff @(posedge ref_clk) begin
      if (clearAll) begin
         matchDone_q <= 1'b0;
         matchHit_q  <= 1'b0;
      end else begin
         matchDone_q <= frameValid;
         if (frameValid) begin
            matchHit_q <= (&bitOk)
                          && (frameIn.rtr == identLow_q[`CWF_LOW_RTR_BIT])
                          && (frameIn.ide == identLow_q[`CWF_LOW_IDE_BIT]); // see R14
         end
      end
   end

   // every output straight from a flip-flop
   assign rdData      = rdData_q;
   assign rdValid     = rdValid_q;
   assign identLow    = identLow_q;
   assign identHigh   = identHigh_q;
   assign maskHigh    = maskHigh_q;
   assign configValid = configValid_q;
   assign matchDone   = matchDone_q;
   assign matchHit    = matchHit_q;

endmodule : cwf_filter_regs

//--- cwf_frame_src.sv
/* frame source standing in for bus nodes sending wake frames.
   assumes: one request pulse per frame from the bench */
`timescale 1ns/100ps
module cwf_frame_src (
   input  wire logic                ref_clk,
   input  wire logic                sendReq,
   input  wire cwf_pkg::cwf_frame_t sendFrame,
   output cwf_pkg::cwf_frame_t      frameIn,
   output logic                     frameValid
);
   initial frameIn = '0;
   initial frameValid = 1'b0;
   // header lasts one cycle; idle shows inverse so stale data never passes
   always @(posedge ref_clk) begin
      frameValid <= sendReq;
      frameIn    <= sendReq ? sendFrame : ~frameIn;
   end
endmodule : cwf_frame_src

//--- cwf_filter_regs_asserts.sv
/* port checks of the wake filter registers.
   assumes: bound to cwf_filter_regs, one clock, sync reset */
`timescale 1ns/100ps
`include "cwf_regs.svh"
module cwf_filter_regs_asserts (
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire logic                 softRstReq,
   input wire logic                 restartReq,
   input wire cwf_pkg::cwf_access_t regAccess,
   input wire logic                 configValidSet,
   input wire logic                 frameValid,
   input wire logic                 rdValid,
   input wire logic [15:0]          identLow,
   input wire logic [15:0]          maskHigh,
   input wire logic                 configValid,
   input wire logic                 matchDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // a write with no reset or restart competing
   sequence quietWr; regAccess.wrEn && !softRstReq && !restartReq; endsequence
   sequence lowWr; quietWr ##0 regAccess.addr == `CWF_ADDR_IDENT_LOW; endsequence
   rsvd_zero_a: assert property (identLow[7] == 1'b0) else $error("reserved bit set");
   low_write_a:
      assert property (lowWr |=> identLow == ($past(regAccess.wrData) & `CWF_WMASK_IDENT_LOW)) else $error("bad low");
   soft_clear_a:
      assert property (softRstReq |=> identLow == 16'h0000 && maskHigh == 16'h0000 && !configValid) else $error("no clear");
   restart_keep_a:
      assert property (restartReq && !softRstReq && !regAccess.wrEn |=> identLow == $past(identLow)
         && maskHigh == $past(maskHigh) && !configValid) else $error("restart lost data");
   cfg_clear_a:
      assert property (quietWr ##0 regAccess.addr inside {[7'h32:7'h34]} |=> !configValid) else $error("valid kept");
   cfg_set_a:
      assert property (configValidSet && !regAccess.wrEn && !softRstReq && !restartReq |=> configValid) else $error("no set");
   rd_latency_a: assert property (regAccess.rdEn && !softRstReq |=> rdValid) else $error("late read");
   rd_pulse_a: assert property (!regAccess.rdEn |=> !rdValid) else $error("stray read");
   match_done_a: assert property (frameValid |=> matchDone ##1 $past(frameValid) || !matchDone) else $error("bad done");
endmodule : cwf_filter_regs_asserts
bind cwf_filter_regs cwf_filter_regs_asserts cwf_filter_regs_asserts_inst (.ref_clk, .rst_n, .softRstReq, .restartReq,
   .regAccess, .configValidSet, .frameValid, .rdValid, .identLow, .maskHigh, .configValid, .matchDone);

//--- tb.sv
/* bench for the wake filter registers: register tasks and filter frames.
   assumes: design, frame source and checker compiled first */
`timescale 1ns/100ps
`include "cwf_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("unexpected %s %h %h", n, e, g); end end
module tb;
   logic                 ref_clk = 1'b0, rst_n = 1'b0, softRstReq = 1'b0, restartReq = 1'b0, configValidSet = 1'b0;
   logic                 sendReq = 1'b0, frameValid, rdValid, configValid, matchDone, matchHit;
   logic [1:0]           c;
   logic [12:0]          maskLow = 13'h1FFF;
   logic [15:0]          rdData, identLow, identHigh, maskHigh, lo;
   logic [28:0]          id = 29'h0ACE1357;
   cwf_pkg::cwf_access_t regAccess = '0;
   cwf_pkg::cwf_frame_t  sendFrame = '0, frameIn;
   int                   err_count = 0, checks = 0;
   always #5 ref_clk = ~ref_clk;
   cwf_filter_regs cwf_filter_regs_inst (.ref_clk, .rst_n, .softRstReq, .restartReq, .regAccess, .configValidSet,
      .maskLow, .frameValid, .frameIn, .rdData, .rdValid, .identLow, .identHigh, .maskHigh, .configValid, .matchDone,
      .matchHit);
   cwf_frame_src cwf_frame_src_inst (.ref_clk, .sendReq, .sendFrame, .frameIn, .frameValid);
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge ref_clk) regAccess <= '{a, 1'b1, 1'b0, d};
      @(posedge ref_clk) regAccess.wrEn <= 1'b0;
   endtask : wr
   // read answer stands one cycle, so it is looked at right after the edge
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge ref_clk) regAccess <= '{a, 1'b0, 1'b1, 16'h0000};
      @(posedge ref_clk) regAccess.rdEn <= 1'b0;
      #1 `CHK("rdValid", 1'b1, rdValid)
      `CHK("rdData", e, rdData)
   endtask : rd
   task automatic ctl(input logic [2:0] p);
      @(posedge ref_clk) {softRstReq, restartReq, configValidSet} <= p;
      @(posedge ref_clk) {softRstReq, restartReq, configValidSet} <= 3'b000;
      #1;
   endtask : ctl
   task automatic frm(input logic r, input logic i, input logic [28:0] f, input logic e);
      @(posedge ref_clk) sendReq <= 1'b1;
      sendFrame <= '{f, r, i};
      @(posedge ref_clk) sendReq <= 1'b0;
      @(posedge ref_clk) #1 `CHK("matchDone", 1'b1, matchDone)
      `CHK("matchHit", e, matchHit)
   endtask : frm
   task automatic end_sim;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // hang guard, far beyond the roughly 130 cycles of the tests
   initial begin
      #20000 err_count++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`CWF_ADDR_IDENT_LOW, `CWF_RST_IDENT_LOW);
      rd(`CWF_ADDR_MASK_HIGH, `CWF_RST_MASK_HIGH);
      wr(`CWF_ADDR_IDENT_LOW, 16'hFFFF);
      rd(`CWF_ADDR_IDENT_LOW, 16'hFF7F);
      wr(`CWF_ADDR_IDENT_LOW, 16'h0080);
      rd(`CWF_ADDR_IDENT_LOW, 16'h0000);
      wr(`CWF_ADDR_MASK_HIGH, 16'hA5C3);
      rd(`CWF_ADDR_MASK_HIGH, 16'hA5C3);
      rd(7'h35, 16'h0000);
      ctl(3'b001);
      `CHK("configValid", 1'b1, configValid)
      wr(`CWF_ADDR_IDENT_HIGH, id[28:13]);
      #1 `CHK("configValid", 1'b0, configValid)
      `CHK("identHigh", id[28:13], identHigh)
      rd(`CWF_ADDR_IDENT_HIGH, id[28:13]);
      wr(`CWF_ADDR_MASK_HIGH, 16'hFFFF);
      // every remote-request and identifier-length setting, hit and miss
      for (int n = 0; n < 4; n++) begin
         c = n[1:0];
         lo = {id[12:5], 1'b0, id[4:0], c};
         wr(`CWF_ADDR_IDENT_LOW, lo);
         ctl(3'b001);
         frm(c[1], c[0], id, 1'b1);
         frm(~c[1], c[0], id, 1'b0);
         frm(c[1], ~c[0], id, 1'b0);
      end
      frm(c[1], c[0], id ^ 29'h00002000, 1'b0);
      wr(`CWF_ADDR_MASK_HIGH, 16'hFFFE);
      frm(c[1], c[0], id ^ 29'h00002000, 1'b1);
      // low-half mask comes in on its own port, so bit 0 is cleared there
      @(posedge ref_clk) maskLow <= 13'h1FFE;
      frm(c[1], c[0], id ^ 29'h00000001, 1'b1);
      @(posedge ref_clk) maskLow <= 13'h1FFF;
      frm(c[1], c[0], id ^ 29'h00000001, 1'b0);
      // arm the flag first so the restart has something to clear
      ctl(3'b001);
      `CHK("configValid", 1'b1, configValid)
      ctl(3'b010);
      `CHK("configValid", 1'b0, configValid)
      rd(`CWF_ADDR_IDENT_LOW, lo);
      rd(`CWF_ADDR_MASK_HIGH, 16'hFFFE);
      ctl(3'b100);
      rd(`CWF_ADDR_IDENT_LOW, `CWF_RST_IDENT_LOW);
      rd(`CWF_ADDR_MASK_HIGH, `CWF_RST_MASK_HIGH);
      end_sim();
   end
endmodule : tb
